// [src/irq_gate_pkg.sv]
package irq_gate_pkg;

  // Register byte offsets on the register port.
  localparam logic [7:0] STATUS_OFFSET = 8'h0c;
  localparam logic [7:0] ENABLE_SET_OFFSET = 8'h10;
  localparam logic [7:0] ENABLE_CLEAR_OFFSET = 8'h14;

  // Bit positions shared by the status and enable registers, except the enable-only bit 31.
  localparam int unsigned MASTER_IRQ_GATE_BIT = 31;
  localparam int unsigned OWNERSHIP_CHANGE_BIT = 30;
  localparam int unsigned ROOT_HUB_CHANGE_BIT = 6;
  localparam int unsigned FRAME_COUNT_OVERFLOW_BIT = 5;
  localparam int unsigned UNRECOVERABLE_FAULT_BIT = 4;
  localparam int unsigned RESUME_DETECT_BIT = 3;
  localparam int unsigned FRAME_START_BIT = 2;
  localparam int unsigned DONE_QUEUE_WRITEBACK_BIT = 1;
  localparam int unsigned SCHEDULE_OVERRUN_BIT = 0;

  // Implemented bits; every other position is reserved and reads as zero.
  localparam logic [31:0] EVENT_BITS_MASK = 32'h4000_007f;
  localparam logic [31:0] ENABLE_BITS_MASK = 32'hc000_007f;

  // Reset values.
  localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

endpackage

// [src/event_status_reg.sv]
`timescale 1ns/1ps
`default_nettype none

module event_status_reg
  import irq_gate_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Event pulses from the controller.
  input wire logic [31:0] event_set_i,
  // Software write-one-to-clear.
  input wire logic clear_wr_i,
  input wire logic [31:0] clear_data_i,
  // Stored status.
  output logic [31:0] status_o
);

  logic [31:0] status_q;
  logic [31:0] status_d;

  // Hardware only sets bits; a set arriving with a clear wins.
  always_comb begin
    status_d = status_q;
    if (clear_wr_i) begin
      status_d = status_d & ~clear_data_i;
    end
    status_d = (status_d | event_set_i) & EVENT_BITS_MASK;
  end

  // Status storage.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q <= STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  assign status_o = status_q;

  // A signalled event is visible in the next cycle.
  property p_event_sets;
    @(posedge clk_i) disable iff (rst_i)
      (|(event_set_i & EVENT_BITS_MASK)) |=>
        ((status_q & $past(event_set_i) & EVENT_BITS_MASK) ==
         ($past(event_set_i) & EVENT_BITS_MASK));
  endproperty
  AST_EVENT_SETS: assert property (p_event_sets) else $error("event bit not set");

  // A bit only falls when software writes one to it.
  property p_no_self_clear;
    @(posedge clk_i) disable iff (rst_i)
      !clear_wr_i |=> ((status_q & $past(status_q)) == $past(status_q));
  endproperty
  AST_NO_SELF_CLEAR: assert property (p_no_self_clear) else $error("status self cleared");

endmodule

`default_nettype wire

// [src/irq_enable_gate.sv]
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Interrupt requested only while status, matching enable and master gate are set.
// - Each enable bit except the master gate bit 31 pairs with the status bit at the same position.
// - Writing 1 to an enable set bit sets that enable bit.
// - Writing 0 to an enable set bit leaves that bit unchanged.
// - Reading the enable register returns all current enable bits.
// - Bit 31 is the master gate permitting all enabled events.
// - Bit 30 enables the ownership change event.
// - Bit 6 enables the root hub change event.
// - Bit 5 enables the frame count overflow event.
// - Bit 4 enables the unrecoverable fault event.
// - Bit 3 enables the resume detection event.
// - Bit 2 enables the frame start event.
// - Bit 1 enables the done queue writeback event.
// - Bit 0 enables the scheduling overrun event.
// - Writing 1 to the clear register clears the enable; reads return enables.
// - Status bits set by events, cleared only by software writing one.

module irq_enable_gate
  import irq_gate_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port.
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Event pulses from the controller.
  input wire logic [31:0] event_set_i,
  // Interrupt request to the host bus.
  output logic irq_o,
  // Observation of stored registers.
  output logic [31:0] status_o,
  output logic [31:0] enable_o
);

  // Address match used by every decode.
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offs);
    addr_hit = (addr == offs);
  endfunction

  logic wr_status;
  logic wr_set;
  logic wr_clear;
  logic [31:0] status;
  logic [31:0] enable_q;
  logic [31:0] enable_d;
  logic [31:0] rdata_q;
  logic rvalid_q;
  logic [7:0] ev_req;
  logic gate;

  // Write decode.
  assign wr_status = reg_wr_i && addr_hit(reg_addr_i, STATUS_OFFSET);
  assign wr_set = reg_wr_i && addr_hit(reg_addr_i, ENABLE_SET_OFFSET);
  assign wr_clear = reg_wr_i && addr_hit(reg_addr_i, ENABLE_CLEAR_OFFSET);

  // Sticky event status, cleared by writing ones.
  event_status_reg u_status (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .event_set_i(event_set_i),
    .clear_wr_i(wr_status),
    .clear_data_i(reg_wdata_i),
    .status_o(status)
  );

  // Ones set or clear enables, zeros leave them; reserved bits never store.
  always_comb begin
    enable_d = enable_q;
    if (wr_set) begin
      enable_d = enable_d | reg_wdata_i;
    end
    if (wr_clear) begin
      enable_d = enable_d & ~reg_wdata_i;
    end
    enable_d = enable_d & ENABLE_BITS_MASK;
  end

  // Enable storage, all cleared at reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_q <= ENABLE_RESET;
    end else begin
      enable_q <= enable_d;
    end
  end

  // Registered read data; unmapped offsets read zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd_i;
      if (!reg_rd_i) begin
        rdata_q <= 32'h0000_0000;
      end else if (addr_hit(reg_addr_i, STATUS_OFFSET)) begin
        rdata_q <= status;
      end else if (addr_hit(reg_addr_i, ENABLE_SET_OFFSET)) begin
        rdata_q <= enable_q;
      end else if (addr_hit(reg_addr_i, ENABLE_CLEAR_OFFSET)) begin
        rdata_q <= enable_q;
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  // Per-event requests pair each status bit with its own enable bit.
  assign ev_req[7] = status[OWNERSHIP_CHANGE_BIT] & enable_q[OWNERSHIP_CHANGE_BIT];
  assign ev_req[6] = status[ROOT_HUB_CHANGE_BIT] & enable_q[ROOT_HUB_CHANGE_BIT];
  assign ev_req[5] = status[FRAME_COUNT_OVERFLOW_BIT] & enable_q[FRAME_COUNT_OVERFLOW_BIT];
  assign ev_req[4] = status[UNRECOVERABLE_FAULT_BIT] & enable_q[UNRECOVERABLE_FAULT_BIT];
  assign ev_req[3] = status[RESUME_DETECT_BIT] & enable_q[RESUME_DETECT_BIT];
  assign ev_req[2] = status[FRAME_START_BIT] & enable_q[FRAME_START_BIT];
  assign ev_req[1] = status[DONE_QUEUE_WRITEBACK_BIT] & enable_q[DONE_QUEUE_WRITEBACK_BIT];
  assign ev_req[0] = status[SCHEDULE_OVERRUN_BIT] & enable_q[SCHEDULE_OVERRUN_BIT];

  // The master gate qualifies the combined request; built from flops only.
  assign gate = enable_q[MASTER_IRQ_GATE_BIT];
  assign irq_o = gate & (|ev_req);

  assign reg_rdata_o = rdata_q;
  assign reg_rvalid_o = rvalid_q;
  assign status_o = status;
  assign enable_o = enable_q;

  // Interrupt implies a pending enabled event under an open gate.
  property p_irq_needs_all;
    @(posedge clk_i) disable iff (rst_i)
      irq_o |-> (enable_q[31] && ((status & enable_q & EVENT_BITS_MASK) != 32'h0));
  endproperty
  AST_IRQ_NEEDS_ALL: assert property (p_irq_needs_all) else $error("irq without cause");

  // A pending enabled event under an open gate always interrupts.
  property p_irq_when_all;
    @(posedge clk_i) disable iff (rst_i)
      (enable_q[31] && ((status & enable_q & EVENT_BITS_MASK) != 32'h0)) |-> irq_o;
  endproperty
  AST_IRQ_WHEN_ALL: assert property (p_irq_when_all) else $error("irq missing");

  // A closed gate keeps the request low even with pending events.
  property p_gate_closed;
    @(posedge clk_i) disable iff (rst_i)
      !enable_q[31] |-> !irq_o;
  endproperty
  AST_GATE_CLOSED: assert property (p_gate_closed) else $error("irq with gate closed");

  // Writing the set register ORs in the written ones and nothing else.
  property p_set_write;
    @(posedge clk_i) disable iff (rst_i)
      (wr_set && !wr_clear) |=>
        (enable_q == (($past(enable_q) | $past(reg_wdata_i)) & ENABLE_BITS_MASK));
  endproperty
  AST_SET_WRITE: assert property (p_set_write) else $error("set write wrong");

  // Zeros written to the set register leave set bits set.
  property p_zero_keeps;
    @(posedge clk_i) disable iff (rst_i)
      wr_set |=> ((enable_q & $past(enable_q)) == $past(enable_q));
  endproperty
  AST_ZERO_KEEPS: assert property (p_zero_keeps) else $error("enable lost on set");

  // Writing the clear register drops exactly the written ones.
  property p_clear_write;
    @(posedge clk_i) disable iff (rst_i)
      (wr_clear && !wr_set) |=> (enable_q == ($past(enable_q) & ~$past(reg_wdata_i)));
  endproperty
  AST_CLEAR_WRITE: assert property (p_clear_write) else $error("clear write wrong");

  // Reads of either enable offset return the enables one cycle later.
  sequence s_enable_read;
    reg_rd_i && !reg_wr_i && (addr_hit(reg_addr_i, ENABLE_SET_OFFSET) ||
                              addr_hit(reg_addr_i, ENABLE_CLEAR_OFFSET));
  endsequence
  property p_enable_read;
    @(posedge clk_i) disable iff (rst_i)
      s_enable_read |=> (reg_rvalid_o && reg_rdata_o == $past(enable_q));
  endproperty
  AST_ENABLE_READ: assert property (p_enable_read) else $error("enable readback wrong");

  // Reserved enable positions never hold a one.
  property p_reserved_zero;
    @(posedge clk_i) disable iff (rst_i)
      (enable_q & ~ENABLE_BITS_MASK) == 32'h0;
  endproperty
  AST_RESERVED_ZERO: assert property (p_reserved_zero) else $error("reserved bit set");

  // After reset every enable is clear and no request is made.
  property p_reset_clear;
    @(posedge clk_i) $past(rst_i) |-> (enable_q == 32'h0 && !irq_o);
  endproperty
  AST_RESET_CLEAR: assert property (p_reset_clear) else $error("enable not reset");

  // Without a read request the answer strobe and data are low in the next cycle.
  property p_idle_read;
    @(posedge clk_i) disable iff (rst_i)
      !reg_rd_i |=> (!reg_rvalid_o && reg_rdata_o == 32'h0000_0000);
  endproperty
  AST_IDLE_READ: assert property (p_idle_read) else $error("stray read answer");

  // A status read returns the stored status one cycle later.
  property p_status_read;
    @(posedge clk_i) disable iff (rst_i)
      (reg_rd_i && addr_hit(reg_addr_i, STATUS_OFFSET)) |=>
        (reg_rvalid_o && reg_rdata_o == $past(status));
  endproperty
  AST_STATUS_READ: assert property (p_status_read) else $error("status readback wrong");

  // Writing one to the master position of the set register opens the gate.
  property p_gate_opens;
    @(posedge clk_i) disable iff (rst_i)
      (wr_set && reg_wdata_i[MASTER_IRQ_GATE_BIT]) |=> enable_q[MASTER_IRQ_GATE_BIT];
  endproperty
  AST_GATE_OPENS: assert property (p_gate_opens) else $error("gate not opened");

endmodule

`default_nettype wire

// [test/tb_ohci_interrupt_enable_gate.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_ohci_interrupt_enable_gate;
  import irq_gate_pkg::*;

  // Stimulus driven at the falling edge, outputs observed from the design.
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic reg_rd_i = 1'b0;
  logic [31:0] event_set_i = 32'h0000_0000;
  logic [31:0] reg_rdata_o;
  logic [31:0] status_o;
  logic [31:0] enable_o;
  logic reg_rvalid_o;
  logic irq_o;
  // Reference copies of the stored registers, kept by the bench.
  logic [31:0] en_m = 32'h0000_0000;
  logic [31:0] st_m = 32'h0000_0000;
  int err_count = 0;
  int checked = 0;
  int bits[8] = '{30, 6, 5, 4, 3, 2, 1, 0};
  logic [7:0] addrs[4] = '{8'h0c, 8'h10, 8'h14, 8'h20};

  // A 25 MHz clock.
  always #20 clk_i = ~clk_i;

  irq_enable_gate dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o),
    .event_set_i(event_set_i),
    .irq_o(irq_o),
    .status_o(status_o),
    .enable_o(enable_o)
  );

  // Request level expected from the reference registers.
  function automatic logic irq_exp(input logic [31:0] st, input logic [31:0] en);
    return en[MASTER_IRQ_GATE_BIT] & (|(st & en & EVENT_BITS_MASK));
  endfunction

  // Read answer expected for an address; unmapped places read zero.
  function automatic logic [31:0] rd_exp(input logic [7:0] a);
    if (a == ENABLE_SET_OFFSET || a == ENABLE_CLEAR_OFFSET) return en_m;
    if (a == STATUS_OFFSET) return st_m;
    return 32'h0000_0000;
  endfunction

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One cycle of the register port and event inputs, then a full comparison.
  task automatic step(input logic wr, input logic rd, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] ev);
    logic [31:0] rexp;
    reg_wr_i = wr;
    reg_rd_i = rd;
    reg_addr_i = a;
    reg_wdata_i = d;
    event_set_i = ev;
    rexp = rd ? rd_exp(a) : 32'h0000_0000;
    if (wr && a == ENABLE_SET_OFFSET) en_m = en_m | (d & ENABLE_BITS_MASK);
    if (wr && a == ENABLE_CLEAR_OFFSET) en_m = en_m & ~d;
    if (wr && a == STATUS_OFFSET) st_m = st_m & ~d;
    st_m = st_m | (ev & EVENT_BITS_MASK);
    @(posedge clk_i);
    @(negedge clk_i);
    chk("enable", en_m, enable_o);
    chk("status", st_m, status_o);
    chk("irq", {31'h0, irq_exp(st_m, en_m)}, {31'h0, irq_o});
    chk("rvalid", {31'h0, rd}, {31'h0, reg_rvalid_o});
    chk("rdata", rexp, reg_rdata_o);
  endtask

  // Holds reset for a number of cycles and checks the cleared state.
  task automatic do_reset(input int n);
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    event_set_i = 32'h0000_0000;
    rst_i = 1'b1;
    repeat (n) @(negedge clk_i);
    chk("reset enable", 32'h0000_0000, enable_o);
    chk("reset status", 32'h0000_0000, status_o);
    chk("reset irq", 32'h0000_0000, {31'h0, irq_o});
    chk("reset rvalid", 32'h0000_0000, {31'h0, reg_rvalid_o});
    chk("reset rdata", 32'h0000_0000, reg_rdata_o);
    rst_i = 1'b0;
    en_m = 32'h0000_0000;
    st_m = 32'h0000_0000;
    // One idle cycle after release before the first request.
    @(negedge clk_i);
    chk("release enable", 32'h0000_0000, enable_o);
    chk("release irq", 32'h0000_0000, {31'h0, irq_o});
    $display("Test reset done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence: reset, every event bit in turn, random traffic, reset again.
  initial begin
    logic [31:0] b;
    void'($urandom(77437));
    do_reset(8);
    foreach (bits[i]) begin
      b = 32'h1 << bits[i];
      step(1'b1, 1'b0, ENABLE_SET_OFFSET, b | 32'h8000_0000, 32'h0);
      step(1'b0, 1'b0, 8'h20, 32'h0, EVENT_BITS_MASK & ~b);
      step(1'b0, 1'b0, 8'h20, 32'h0, b);
      step(1'b1, 1'b1, ENABLE_SET_OFFSET, 32'h0, 32'h0);
      step(1'b1, 1'b1, ENABLE_CLEAR_OFFSET, 32'h8000_0000, 32'h0);
      step(1'b1, 1'b0, ENABLE_SET_OFFSET, 32'h8000_0000, 32'h0);
      step(1'b1, 1'b0, ENABLE_CLEAR_OFFSET, b | 32'h8000_0000, 32'h0);
      step(1'b1, 1'b1, STATUS_OFFSET, EVENT_BITS_MASK, 32'h0);
    end
    $display("Test event bits done");
    repeat (300) begin
      step($urandom_range(0, 2) == 0, $urandom_range(0, 2) == 0, addrs[$urandom_range(0, 3)],
           $urandom & ENABLE_BITS_MASK, $urandom & $urandom & $urandom);
    end
    $display("Test random traffic done");
    step(1'b1, 1'b0, ENABLE_SET_OFFSET, ENABLE_BITS_MASK, 32'h0);
    do_reset(2);
    results();
  end

  // Cuts a hang short well beyond the expected run of about 380 cycles.
  initial begin
    #100000;
    err_count++;
    $display("[ERR] watchdog expected finish seen timeout");
    results();
  end

endmodule

`default_nettype wire
